/* File: include/cat_pkg.sv */
// Package for the counter array time base: offsets, fields, resets, types
package cat_pkg;
  // Register offsets (8-bit register port)
  localparam logic [7:0] ADDR_LOW_RELOAD = 8'hCE;
  localparam logic [7:0] ADDR_HIGH_RELOAD = 8'hCF;
  localparam logic [7:0] ADDR_RUN_FLAGS = 8'hD8;
  localparam logic [7:0] ADDR_MODE = 8'hD9;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hE9;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hF9;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hC0;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hC1;

  // Run and flags register fields
  localparam int OVF_FLAG_BIT = 7;
  localparam int RUN_BIT = 6;
  localparam int EVENT_FLAG_LSB = 0;
  localparam int NUM_MODULES = 4;
  // Mode register fields
  localparam int PAIR23_BUF_BIT = 5;
  localparam int PAIR01_BUF_BIT = 4;
  localparam int SRC_SEL_LSB = 1;
  localparam int OVF_IRQ_EN_BIT = 0;
  localparam logic [7:0] MODE_WRITE_MASK = 8'h3F;

  localparam logic [7:0] REG_RESET = 8'h00;

  // Divider figures
  localparam int DIV12 = 12;
  localparam logic [3:0] DIV12_LAST = 4'(DIV12 - 1);

  typedef enum logic [2:0] {
    SRC_DIV12 = 3'h0,
    SRC_DIV2 = 3'h1,
    SRC_TIMER0 = 3'h2,
    SRC_EXT_PIN = 3'h3,
    SRC_RSVD4 = 3'h4,
    SRC_SYSCLK = 3'h5,
    SRC_BAUD_GEN = 3'h6,
    SRC_RSVD7 = 3'h7
  } cat_src_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cat_bus_req_t;

  // Interrupt status layout
  typedef struct packed {
    logic [2:0] unused;
    logic overflow;
    logic [3:0] modEvent;
  } cat_irq_t;
endpackage

/* File: rtl/cat_timebase.sv */
// Counter array shared 16-bit time base with flags and register port
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
// Functional notes
// - Pair 0/1 buffer enable, valid only in suitable modes
// - Sources 000 /12, 001 /2, 101 /1
// - Sources 010 timer0, 011 pin, 110 baud gen
// - External pin counts falling edges
// - Overflow loads reload bytes into count
// - Interrupt while overflow flag and enable set
// - Counts only while run bit set by software
// - Overflow flag set on 16-bit rollover
// - Only software clears overflow flag
// - Software writing one sets overflow flag
// - Module event flags set on match/capture
// - Only software clears module event flags
// - Count bytes readable and writable
// - Reload bytes readable and writable
// - Everything resets to zero
module cat_timebase #(
  parameter int COUNT_WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire cat_pkg::cat_bus_req_t busReq,
  output logic [7:0] rdata,
  input wire logic extCountInput,
  input wire logic timer0Overflow,
  input wire logic serialBaudGenOverflow,
  input wire logic [cat_pkg::NUM_MODULES-1:0] moduleEvent,
  input wire logic [cat_pkg::NUM_MODULES-1:0] pairBufferEligible,
  output logic [COUNT_WIDTH-1:0] countValue,
  output logic countOverflow,
  output logic pair01BufferActive,
  output logic pair23BufferActive,
  output logic counterArrayIrq,
  output logic irqLine
);
  import cat_pkg::*;

  // Byte-wide count registers only serve a 16-bit time base
  if (COUNT_WIDTH != 16) begin : g_bad_width
    $error("cat_timebase: COUNT_WIDTH must be 16");
  end

  logic [7:0] lowReload_q, highReload_q, countLow_q, countHigh_q;
  logic [7:0] modeReg_q;
  logic runControl_q, overflowFlag_q;
  logic [NUM_MODULES-1:0] eventFlag_q;
  logic [7:0] irqStatus_q, irqMask_q;
  logic [3:0] div12_q;
  logic div2_q;
  logic [2:0] extSync_q;
  logic [1:0] t0Sync_q, baudSync_q;
  logic t0Prev_q, baudPrev_q;
  logic [7:0] rdata_q;

  logic wrEn, rdEn;
  logic tick, rollover;
  logic extFall, t0Rise, baudRise;
  cat_src_t srcSel;
  cat_irq_t irqEvents;

  assign wrEn = busReq.wr;
  assign rdEn = busReq.rd;
  assign srcSel = cat_src_t'(modeReg_q[SRC_SEL_LSB +: 3]);

  // Pin and foreign strobes pass two flops before edge detection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      extSync_q <= 3'h0;
      t0Sync_q <= 2'h0;
      baudSync_q <= 2'h0;
      t0Prev_q <= 1'b0;
      baudPrev_q <= 1'b0;
    end else begin
      extSync_q <= {extSync_q[1:0], extCountInput};
      t0Sync_q <= {t0Sync_q[0], timer0Overflow};
      baudSync_q <= {baudSync_q[0], serialBaudGenOverflow};
      t0Prev_q <= t0Sync_q[1];
      baudPrev_q <= baudSync_q[1];
    end
  end

  assign extFall = extSync_q[2] & ~extSync_q[1];
  assign t0Rise = t0Sync_q[1] & ~t0Prev_q;
  assign baudRise = baudSync_q[1] & ~baudPrev_q;

  // Prescalers free run so a source switch never waits for a reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div12_q <= 4'h0;
      div2_q <= 1'b0;
    end else begin
      div12_q <= (div12_q == DIV12_LAST) ? 4'h0 : div12_q + 4'h1;
      div2_q <= ~div2_q;
    end
  end

  always_comb begin
    tick = 1'b0;
    case (srcSel)
      SRC_DIV12: tick = (div12_q == DIV12_LAST);
      SRC_DIV2: tick = div2_q;
      SRC_SYSCLK: tick = 1'b1;
      SRC_TIMER0: tick = t0Rise;
      SRC_EXT_PIN: tick = extFall;
      SRC_BAUD_GEN: tick = baudRise;
      default: tick = 1'b0;
    endcase
  end

  assign rollover = runControl_q & tick & ({countHigh_q, countLow_q} == 16'hFFFF);

  // Count bytes: software write wins over a tick in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      countLow_q <= REG_RESET;
      countHigh_q <= REG_RESET;
    end else begin
      if (wrEn && busReq.addr == ADDR_COUNT_LOW) begin
        countLow_q <= busReq.wdata;
      end else if (rollover) begin
        countLow_q <= lowReload_q;
      end else if (runControl_q && tick) begin
        countLow_q <= countLow_q + 8'h01;
      end
      if (wrEn && busReq.addr == ADDR_COUNT_HIGH) begin
        countHigh_q <= busReq.wdata;
      end else if (rollover) begin
        countHigh_q <= highReload_q;
      end else if (runControl_q && tick && countLow_q == 8'hFF) begin
        countHigh_q <= countHigh_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lowReload_q <= REG_RESET;
      highReload_q <= REG_RESET;
    end else begin
      if (wrEn && busReq.addr == ADDR_LOW_RELOAD) begin
        lowReload_q <= busReq.wdata;
      end
      if (wrEn && busReq.addr == ADDR_HIGH_RELOAD) begin
        highReload_q <= busReq.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      modeReg_q <= REG_RESET;
    end else if (wrEn && busReq.addr == ADDR_MODE) begin
      modeReg_q <= busReq.wdata & MODE_WRITE_MASK;
    end
  end

  // Run bit moves only on software writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      runControl_q <= 1'b0;
    end else if (wrEn && busReq.addr == ADDR_RUN_FLAGS) begin
      runControl_q <= busReq.wdata[RUN_BIT];
    end
  end

  // Hardware only sets; a set in the cycle of a clear wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      overflowFlag_q <= 1'b0;
      eventFlag_q <= '0;
    end else begin
      if (rollover) begin
        overflowFlag_q <= 1'b1;
      end else if (wrEn && busReq.addr == ADDR_RUN_FLAGS) begin
        overflowFlag_q <= busReq.wdata[OVF_FLAG_BIT];
      end
      for (int i = 0; i < NUM_MODULES; i++) begin
        if (moduleEvent[i]) begin
          eventFlag_q[i] <= 1'b1;
        end else if (wrEn && busReq.addr == ADDR_RUN_FLAGS) begin
          eventFlag_q[i] <= busReq.wdata[EVENT_FLAG_LSB + i];
        end
      end
    end
  end

  // Sticky status, cleared by its read; new event wins over the read
  always_comb begin
    irqEvents = '0;
    irqEvents.overflow = rollover;
    irqEvents.modEvent = moduleEvent;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStatus_q <= REG_RESET;
      irqMask_q <= REG_RESET;
    end else begin
      if (rdEn && busReq.addr == ADDR_IRQ_STATUS) begin
        irqStatus_q <= irqEvents;
      end else begin
        irqStatus_q <= irqStatus_q | irqEvents;
      end
      if (wrEn && busReq.addr == ADDR_IRQ_MASK) begin
        irqMask_q <= busReq.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (rdEn) begin
      if (busReq.addr == ADDR_LOW_RELOAD) begin
        rdata_q <= lowReload_q;
      end else if (busReq.addr == ADDR_HIGH_RELOAD) begin
        rdata_q <= highReload_q;
      end else if (busReq.addr == ADDR_RUN_FLAGS) begin
        rdata_q <= {overflowFlag_q, runControl_q, 2'b00, eventFlag_q};
      end else if (busReq.addr == ADDR_MODE) begin
        rdata_q <= modeReg_q;
      end else if (busReq.addr == ADDR_COUNT_LOW) begin
        rdata_q <= countLow_q;
      end else if (busReq.addr == ADDR_COUNT_HIGH) begin
        rdata_q <= countHigh_q;
      end else if (busReq.addr == ADDR_IRQ_STATUS) begin
        rdata_q <= irqStatus_q;
      end else if (busReq.addr == ADDR_IRQ_MASK) begin
        rdata_q <= irqMask_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata = rdata_q;
  assign countValue = {countHigh_q, countLow_q};
  assign countOverflow = rollover;
  // Buffering only when both modules of the pair are eligible
  assign pair01BufferActive = modeReg_q[PAIR01_BUF_BIT] & pairBufferEligible[0]
                              & pairBufferEligible[1];
  assign pair23BufferActive = modeReg_q[PAIR23_BUF_BIT] & pairBufferEligible[2]
                              & pairBufferEligible[3];
  assign counterArrayIrq = overflowFlag_q & modeReg_q[OVF_IRQ_EN_BIT];
  assign irqLine = |(irqStatus_q & irqMask_q);
endmodule // cat_timebase

/* File: tb/cat_timebase_asserts.sv */
// Port-level checker for the counter array time base
`timescale 1ns/1ps
module cat_timebase_asserts #(
  parameter int COUNT_WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire cat_pkg::cat_bus_req_t busReq,
  input wire logic [7:0] rdata,
  input wire logic [cat_pkg::NUM_MODULES-1:0] moduleEvent,
  input wire logic [cat_pkg::NUM_MODULES-1:0] pairBufferEligible,
  input wire logic [COUNT_WIDTH-1:0] countValue,
  input wire logic countOverflow,
  input wire logic pair01BufferActive,
  input wire logic pair23BufferActive,
  input wire logic counterArrayIrq,
  input wire logic irqLine
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_ovf_top; countOverflow |-> countValue == '1; endproperty
  a_ovf_top: assert property (p_ovf_top) else $error("overflow away from top");
  property p_pair01; pair01BufferActive |-> &pairBufferEligible[1:0]; endproperty
  a_pair01: assert property (p_pair01) else $error("pair01 buffer not eligible");
  property p_pair23; pair23BufferActive |-> &pairBufferEligible[3:2]; endproperty
  a_pair23: assert property (p_pair23) else $error("pair23 buffer not eligible");
  property p_rdata; rdata != 8'h00 |-> $past(busReq.rd); endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside its slot");
  property p_step;
    !$past(busReq.wr) && !$past(countOverflow) |-> countValue - $past(countValue) <= 1;
  endproperty
  a_step: assert property (p_step) else $error("count moved by more than one");
  property p_irq_quiet;
    !$past(busReq.wr) && !$past(countOverflow) |-> $stable(counterArrayIrq);
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq changed by itself");
  property p_line_rise;
    $rose(irqLine) |-> $past(|moduleEvent) || $past(countOverflow) || $past(busReq.wr);
  endproperty
  a_line_rise: assert property (p_line_rise) else $error("irq line rose without event");
  property p_line_fall; $fell(irqLine) |-> $past(busReq.rd) || $past(busReq.wr); endproperty
  a_line_fall: assert property (p_line_fall) else $error("irq line fell by itself");
  c_ovf: cover property (countOverflow);
  c_line: cover property ($rose(irqLine));
  c_buf: cover property (pair01BufferActive);
endmodule // cat_timebase_asserts
bind cat_timebase cat_timebase_asserts #(.COUNT_WIDTH(COUNT_WIDTH)) cat_timebase_asserts_i (.*);

/* File: tb/cat_timebase_bench.sv */
// Register-level bench for the counter array time base
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module cat_timebase_bench;
  import cat_pkg::*;
  logic clk = 0;
  logic reset_n = 0;
  cat_bus_req_t busReq = '0;
  logic [2:0] srcIn = 3'h2;
  logic [3:0] moduleEvent = 4'h0;
  logic [3:0] pairBufferEligible = 4'h0;
  logic [7:0] rdata;
  logic [15:0] countValue, c0;
  logic countOverflow, p01, p23, caIrq, irqLine;
  logic [7:0] regs [6] = '{8'hCE, 8'hCF, 8'hD8, 8'hD9, 8'hE9, 8'hF9};
  logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h5, 3'h4, 3'h7};
  logic [15:0] exp24 [5] = '{16'h0002, 16'h000C, 16'h0018, 16'h0000, 16'h0000};
  logic [2:0] pins [3] = '{3'h2, 3'h3, 3'h6};
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  cat_timebase cat_timebase_i (.clk(clk), .reset_n(reset_n), .busReq(busReq), .rdata(rdata),
    .extCountInput(srcIn[1]), .timer0Overflow(srcIn[0]), .serialBaudGenOverflow(srcIn[2]),
    .moduleEvent(moduleEvent), .pairBufferEligible(pairBufferEligible),
    .countValue(countValue), .countOverflow(countOverflow), .pair01BufferActive(p01),
    .pair23BufferActive(p23), .counterArrayIrq(caIrq), .irqLine(irqLine));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Gap cycle after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    foreach (regs[i]) rd(regs[i], 8'h00);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h1E);
    moduleEvent <= 4'h5;
    @(posedge clk);
    moduleEvent <= 4'h0;
    @(posedge clk);
    `CHK(irqLine, 1'b1)
    rd(ADDR_RUN_FLAGS, 8'h05);
    rd(ADDR_IRQ_STATUS, 8'h05);
    `CHK(irqLine, 1'b0)
    wr(ADDR_RUN_FLAGS, 8'h01);
    rd(ADDR_RUN_FLAGS, 8'h01);
    moduleEvent <= 4'h1;
    @(posedge clk);
    moduleEvent <= 4'h0;
    @(posedge clk);
    `CHK(irqLine, 1'b0)
    wr(ADDR_MODE, 8'hFF);
    rd(ADDR_MODE, 8'h3F);
    pairBufferEligible <= 4'h7;
    @(negedge clk);
    `CHK({p01, p23}, 2'b10)
    @(posedge clk);
    pairBufferEligible <= 4'hE;
    @(negedge clk);
    `CHK({p01, p23}, 2'b01)
    @(posedge clk);
    wr(ADDR_LOW_RELOAD, 8'h34);
    wr(ADDR_HIGH_RELOAD, 8'h12);
    wr(ADDR_COUNT_LOW, 8'hFD);
    wr(ADDR_COUNT_HIGH, 8'hFF);
    rd(ADDR_HIGH_RELOAD, 8'h12);
    rd(ADDR_COUNT_LOW, 8'hFD);
    wr(ADDR_MODE, 8'h0B);
    wr(ADDR_RUN_FLAGS, 8'h70);
    for (int i = 0; i < 50 && countOverflow !== 1'b1; i++) @(negedge clk);
    `CHK(countOverflow, 1'b1)
    @(negedge clk);
    `CHK(countValue, 16'h1234)
    `CHK({caIrq, irqLine}, 2'b11)
    @(posedge clk);
    rd(ADDR_IRQ_STATUS, 8'h11);
    wr(ADDR_RUN_FLAGS, 8'h80);
    c0 = countValue;
    repeat (5) @(posedge clk);
    `CHK(countValue, c0)
    rd(ADDR_RUN_FLAGS, 8'h80);
    wr(ADDR_RUN_FLAGS, 8'h00);
    `CHK(caIrq, 1'b0)
    wr(ADDR_RUN_FLAGS, 8'h80);
    `CHK(caIrq, 1'b1)
    wr(ADDR_MODE, 8'h0A);
    `CHK(caIrq, 1'b0)
    wr(ADDR_RUN_FLAGS, 8'h40);
    foreach (codes[i]) begin
      wr(ADDR_MODE, {4'h0, codes[i], 1'b0});
      // Running count can move on any rising clock edge, so sample at falling edges
      @(negedge clk);
      c0 = countValue;
      repeat (24) @(negedge clk);
      `CHK(countValue - c0, exp24[i])
      @(posedge clk);
    end
    // Each pulse gives one counted edge whatever the pin's idle level
    foreach (pins[i]) begin
      wr(ADDR_MODE, {4'h0, pins[i], 1'b0});
      c0 = countValue;
      repeat (3) begin
        srcIn[i] <= ~srcIn[i];
        repeat (2) @(posedge clk);
        srcIn[i] <= ~srcIn[i];
        repeat (2) @(posedge clk);
      end
      repeat (6) @(posedge clk);
      `CHK(countValue - c0, 16'h0003)
    end
    complete_run();
  end
endmodule // cat_timebase_bench
